// [hw/aor_params.svh]
`ifndef AOR_PARAMS_SVH
`define AOR_PARAMS_SVH

`define AOR_DATA_W        32
`define AOR_ADDR_W        18
`define AOR_IDX_W         16
`define AOR_NUM_ASRC      8
`define AOR_NUM_PAIR      24
`define AOR_NUM_CHAN      48
`define AOR_NUM_ASRC_CHAN 16
`define AOR_NUM_PDM       4
`define AOR_NUM_RATE_SRC  12

`define AOR_RATE_IDX_BASE 16'hF140
`define AOR_RATE_IDX_LAST 16'hF147
`define AOR_SRC_IDX_BASE  16'hF180
`define AOR_SRC_IDX_LAST  16'hF197

`define AOR_RATE_W        4
`define AOR_SRC_W         6
`define AOR_CODE_LSB      0
`define AOR_CODE_W        3
`define AOR_ASEL_LSB      3
`define AOR_ASEL_W        3
`define AOR_RESET_VAL     16'h0000

`define AOR_RATE_NONE     4'h0
`define AOR_RATE_SOUT0    4'h1
`define AOR_RATE_SOUT1    4'h2
`define AOR_RATE_SOUT2    4'h3
`define AOR_RATE_SOUT3    4'h4
`define AOR_RATE_DSP      4'h5
`define AOR_RATE_CG1_X1   4'h6
`define AOR_RATE_CG1_X2   4'h7
`define AOR_RATE_CG1_X4   4'h8
`define AOR_RATE_CG1_D2   4'h9
`define AOR_RATE_CG2_D3   4'hA
`define AOR_RATE_CG1_D4   4'hB
`define AOR_RATE_CG2_D6   4'hC

`define AOR_SRC_OFF       3'h0
`define AOR_SRC_SIN       3'h1
`define AOR_SRC_DSP       3'h2
`define AOR_SRC_ASRC      3'h3
`define AOR_SRC_PDM01     3'h4
`define AOR_SRC_PDM23     3'h5

`endif

// [hw/aor_pkg.sv]
`include "aor_params.svh"

package aor_pkg;

  typedef logic [`AOR_DATA_W-1:0] aor_word_t;

  typedef struct packed {
    logic [`AOR_ADDR_W-1:0] paddr;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    aor_word_t              pwdata;
  } aor_apb_req_t;

  typedef struct packed {
    aor_word_t prdata;
    logic      pready;
    logic      pslverr;
  } aor_apb_rsp_t;

  typedef aor_word_t [`AOR_NUM_CHAN-1:0]      aor_chan_t;
  typedef aor_word_t [`AOR_NUM_ASRC_CHAN-1:0] aor_asrc_chan_t;
  typedef aor_word_t [`AOR_NUM_PDM-1:0]       aor_pdm_chan_t;
  typedef logic [`AOR_NUM_RATE_SRC-1:0]      aor_rate_sel_t;

  typedef struct packed {
    logic [`AOR_NUM_ASRC-1:0][`AOR_RATE_W-1:0] rate;
    logic [`AOR_NUM_PAIR-1:0][`AOR_SRC_W-1:0]  src;
    aor_apb_rsp_t                              rsp;
    aor_chan_t                                 sout;
    logic [`AOR_NUM_PAIR-1:0]                  pair_on;
    logic [`AOR_NUM_ASRC-1:0]                  rate_tick;
    logic [`AOR_NUM_ASRC-1:0]                  rate_valid;
  } aor_state_t;

endpackage : aor_pkg

// [hw/aor_route.sv]
// Operation
// - Each resampler rate selector holds a 4-bit code, reset zero meaning no rate.
// - Codes 1 to 4 lock the resampler to serial output port 0 to 3 rate.
// - Code 5 locks the resampler to the DSP core sampling rate.
// - Codes 6, 7, 8 give clock generator 1 base rate times 1, 2, 4.
// - Code 9 gives half, code 11 a quarter, of clock generator 1 rate.
// - Code 10 gives a third, code 12 a sixth, of clock generator 2 rate.
// - 24 pair source selectors; selector n drives output channels 2n and 2n+1.
// - Selectors 0 to 7 drive channels 0 to 15 on serial output port 0.
// - Selectors 8 to 15 drive channels 16 to 31 on serial output port 1.
// - Selectors 16 to 19 drive channels 32 to 39 on serial output port 2.
// - Selectors 20 to 23 drive channels 40 to 47 on serial output port 3.
// - Source code 3 takes resampler k channels 2k, 2k+1 from a 3-bit field.
// - Selector bits 15 to 6 are reserved and read zero.
// - Source 0 off, 1 serial in, 2 DSP, 3 resampler, 4/5 PDM pairs.
// - Rate selectors sit at consecutive indices from F140, one per stereo resampler.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "aor_params.svh"

module aor_route (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire aor_pkg::aor_apb_req_t  apb_req,
  output aor_pkg::aor_apb_rsp_t       apb_rsp,
  input  wire aor_pkg::aor_chan_t      serial_in,
  input  wire aor_pkg::aor_chan_t      dsp_out,
  input  wire aor_pkg::aor_asrc_chan_t asrc_out,
  input  wire aor_pkg::aor_pdm_chan_t  pdm_in,
  input  wire aor_pkg::aor_rate_sel_t  rate_strobe,
  output logic [16*`AOR_DATA_W-1:0]   serial_out_port_0,
  output logic [16*`AOR_DATA_W-1:0]   serial_out_port_1,
  output logic [8*`AOR_DATA_W-1:0]    serial_out_port_2,
  output logic [8*`AOR_DATA_W-1:0]    serial_out_port_3,
  output logic [`AOR_NUM_PAIR-1:0]    pair_active,
  output logic [`AOR_NUM_ASRC-1:0]    resampler_rate_tick,
  output logic [`AOR_NUM_ASRC-1:0]    resampler_rate_valid
);

  aor_pkg::aor_state_t state_q;
  aor_pkg::aor_state_t state_d;

  // Printed offsets step by one, so the word index is the printed offset
  function automatic logic is_rate(input logic [`AOR_IDX_W-1:0] idx);
    is_rate = (idx >= `AOR_RATE_IDX_BASE) && (idx <= `AOR_RATE_IDX_LAST);
  endfunction : is_rate

  function automatic logic is_src(input logic [`AOR_IDX_W-1:0] idx);
    is_src = (idx >= `AOR_SRC_IDX_BASE) && (idx <= `AOR_SRC_IDX_LAST);
  endfunction : is_src

  // One-hot pick among the rate strobes; bit i serves code i+1
  function automatic aor_pkg::aor_rate_sel_t rate_decode(input logic [`AOR_RATE_W-1:0] code);
    rate_decode = '0;
    unique case (code)
      `AOR_RATE_SOUT0:  rate_decode[0]  = 1'b1;
      `AOR_RATE_SOUT1:  rate_decode[1]  = 1'b1;
      `AOR_RATE_SOUT2:  rate_decode[2]  = 1'b1;
      `AOR_RATE_SOUT3:  rate_decode[3]  = 1'b1;
      `AOR_RATE_DSP:    rate_decode[4]  = 1'b1;
      `AOR_RATE_CG1_X1: rate_decode[5]  = 1'b1;
      `AOR_RATE_CG1_X2: rate_decode[6]  = 1'b1;
      `AOR_RATE_CG1_X4: rate_decode[7]  = 1'b1;
      `AOR_RATE_CG1_D2: rate_decode[8]  = 1'b1;
      `AOR_RATE_CG2_D3: rate_decode[9]  = 1'b1;
      `AOR_RATE_CG1_D4: rate_decode[10] = 1'b1;
      `AOR_RATE_CG2_D6: rate_decode[11] = 1'b1;
      // Unused codes select nothing so the resampler never sees a stray clock
      default:          rate_decode     = '0;
    endcase
  endfunction : rate_decode

  always_comb begin
    logic [`AOR_IDX_W-1:0]  idx;
    logic                   setup;
    logic                   access;
    logic                   mapped;
    logic [2:0]             rk;
    logic [4:0]             sk;
    logic [`AOR_CODE_W-1:0] code;
    logic [`AOR_ASEL_W-1:0] asel;
    aor_pkg::aor_rate_sel_t sel;
    idx    = apb_req.paddr[`AOR_ADDR_W-1:2];
    setup  = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable & state_q.rsp.pready;
    mapped = (apb_req.paddr[1:0] == 2'h0) && (is_rate(idx) || is_src(idx));
    rk     = 3'(idx - `AOR_RATE_IDX_BASE);
    sk     = 5'(idx - `AOR_SRC_IDX_BASE);
    code   = '0;
    asel   = '0;
    sel    = '0;
    state_d = state_q;

    // Zero-wait slave: the answer is prepared in setup and shown in access
    state_d.rsp.pready  = setup;
    state_d.rsp.pslverr = setup & ~mapped;
    state_d.rsp.prdata  = '0;
    if (setup && mapped && is_rate(idx)) begin
      state_d.rsp.prdata = 32'(state_q.rate[rk]);
    end
    if (setup && mapped && is_src(idx)) begin
      state_d.rsp.prdata = 32'(state_q.src[sk]);
    end

    // Writes land only at the completing edge of an error-free access
    if (access && apb_req.pwrite && !state_q.rsp.pslverr) begin
      if (is_rate(idx)) begin
        state_d.rate[rk] = apb_req.pwdata[`AOR_RATE_W-1:0];
      end
      if (is_src(idx)) begin
        state_d.src[sk] = apb_req.pwdata[`AOR_SRC_W-1:0];
      end
    end

    for (int k = 0; k < `AOR_NUM_ASRC; k++) begin
      sel = rate_decode(state_q.rate[k]);
      state_d.rate_valid[k] = |sel;
      state_d.rate_tick[k]  = |(sel & rate_strobe);
    end

    for (int n = 0; n < `AOR_NUM_PAIR; n++) begin
      code = state_q.src[n][`AOR_CODE_LSB +: `AOR_CODE_W];
      asel = state_q.src[n][`AOR_ASEL_LSB +: `AOR_ASEL_W];
      state_d.pair_on[n]    = 1'b1;
      state_d.sout[2*n]     = '0;
      state_d.sout[2*n+1]   = '0;
      unique case (code)
        `AOR_SRC_SIN: begin
          state_d.sout[2*n]   = serial_in[2*n];
          state_d.sout[2*n+1] = serial_in[2*n+1];
        end
        `AOR_SRC_DSP: begin
          state_d.sout[2*n]   = dsp_out[2*n];
          state_d.sout[2*n+1] = dsp_out[2*n+1];
        end
        `AOR_SRC_ASRC: begin
          state_d.sout[2*n]   = asrc_out[2*asel];
          state_d.sout[2*n+1] = asrc_out[2*asel+1];
        end
        `AOR_SRC_PDM01: begin
          state_d.sout[2*n]   = pdm_in[0];
          state_d.sout[2*n+1] = pdm_in[1];
        end
        `AOR_SRC_PDM23: begin
          state_d.sout[2*n]   = pdm_in[2];
          state_d.sout[2*n+1] = pdm_in[3];
        end
        // Off and the two spare codes drive silence
        default: state_d.pair_on[n] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Pair n feeds channels 2n and 2n+1 of the flat output bus
  assign apb_rsp              = state_q.rsp;
  assign serial_out_port_0    = state_q.sout[15:0];
  assign serial_out_port_1    = state_q.sout[31:16];
  assign serial_out_port_2    = state_q.sout[39:32];
  assign serial_out_port_3    = state_q.sout[47:40];
  assign pair_active          = state_q.pair_on;
  assign resampler_rate_tick  = state_q.rate_tick;
  assign resampler_rate_valid = state_q.rate_valid;

endmodule : aor_route

// [verif/aor_route_asserts.sv]
`timescale 1ns/1ps
`include "aor_params.svh"
module aor_route_asserts (
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  input wire aor_pkg::aor_apb_req_t        apb_req,
  input wire aor_pkg::aor_apb_rsp_t        apb_rsp,
  input wire aor_pkg::aor_rate_sel_t       rate_strobe,
  input wire logic [16*`AOR_DATA_W-1:0]    serial_out_port_0,
  input wire logic [`AOR_NUM_PAIR-1:0]     pair_active,
  input wire logic [`AOR_NUM_ASRC-1:0]     resampler_rate_tick,
  input wire logic [`AOR_NUM_ASRC-1:0]     resampler_rate_valid
);
  logic [15:0] idx;
  logic        hit;
  assign idx = apb_req.paddr[17:2];
  assign hit = (apb_req.paddr[1:0] == 2'h0) && ((idx >= 16'hF140 && idx <= 16'hF147)
               || (idx >= 16'hF180 && idx <= 16'hF197));
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !hit)
    else $error("error flag wrong for address");
  a_err_data_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("data on refused access");
  a_rsv_read_zero: assert property (apb_rsp.pready && !apb_req.pwrite |-> apb_rsp.prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");
  a_pair_off_quiet: assert property (!pair_active[0] |-> serial_out_port_0[63:0] == 64'h0)
    else $error("inactive pair not silent");
  a_reset_quiet: assert property ($rose(rst_b) |-> pair_active == 24'h0 && resampler_rate_valid == 8'h0)
    else $error("outputs not clear after reset");
  a_tick_needs_valid: assert property ((resampler_rate_tick & ~resampler_rate_valid) == 8'h0)
    else $error("tick without rate");
  a_tick_from_strobe: assert property (rate_strobe == 12'h0 |=> resampler_rate_tick == 8'h0)
    else $error("tick without strobe");
  c_refused: cover property (apb_rsp.pslverr);
  c_pair_on: cover property (pair_active == 24'hFFFFFF);
  c_tick: cover property (resampler_rate_tick != 8'h0);
endmodule : aor_route_asserts
bind aor_route aor_route_asserts u_chk (.*);

// [verif/aor_far_model.sv]
`timescale 1ns/1ps
module aor_far_model (
  input  wire logic              sys_clk,
  output aor_pkg::aor_chan_t      serial_in,
  output aor_pkg::aor_chan_t      dsp_out,
  output aor_pkg::aor_asrc_chan_t asrc_out,
  output aor_pkg::aor_pdm_chan_t  pdm_in,
  output aor_pkg::aor_rate_sel_t  rate_strobe
);
  integer seed;
  // Fresh samples every cycle, so a stale or wrong route cannot match
  initial begin
    seed = 47400;
    serial_in = '0;
    dsp_out = '0;
    asrc_out = '0;
    pdm_in = '0;
    rate_strobe = '0;
    forever begin
      @(posedge sys_clk);
      for (int i = 0; i < 48; i++) begin
        serial_in[i] <= $random(seed);
        dsp_out[i] <= $random(seed);
        if (i < 16) asrc_out[i] <= $random(seed);
        if (i < 4) pdm_in[i] <= $random(seed);
      end
      rate_strobe <= $random(seed);
    end
  end
endmodule : aor_far_model

// [verif/test_audio_output_route_and_target_rate_code_select.sv]
`timescale 1ns/1ps
`include "aor_params.svh"
module test_audio_output_route_and_target_rate_code_select;
  logic                      sys_clk, rst_b;
  aor_pkg::aor_apb_req_t     apb_req;
  aor_pkg::aor_apb_rsp_t     apb_rsp;
  aor_pkg::aor_chan_t        serial_in, dsp_out, all_out, s_si, s_dsp;
  aor_pkg::aor_asrc_chan_t   asrc_out, s_as;
  aor_pkg::aor_pdm_chan_t    pdm_in, s_pdm;
  aor_pkg::aor_rate_sel_t    rate_strobe, s_rs;
  logic [16*`AOR_DATA_W-1:0] p0, p1;
  logic [8*`AOR_DATA_W-1:0]  p2, p3;
  logic [23:0]               pact;
  logic [7:0]                tick, valid;
  logic [32:0]               expq[$];
  logic [31:0]               d, e;
  logic [3:0]                code;
  integer                    err_total, checked, seed, c, n, j, v;
  assign all_out = {p3, p2, p1, p0};
  aor_far_model far (.sys_clk(sys_clk), .serial_in(serial_in), .dsp_out(dsp_out),
    .asrc_out(asrc_out), .pdm_in(pdm_in), .rate_strobe(rate_strobe));
  aor_route uut (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .serial_in(serial_in), .dsp_out(dsp_out), .asrc_out(asrc_out), .pdm_in(pdm_in),
    .rate_strobe(rate_strobe), .serial_out_port_0(p0), .serial_out_port_1(p1),
    .serial_out_port_2(p2), .serial_out_port_3(p3), .pair_active(pact),
    .resampler_rate_tick(tick), .resampler_rate_valid(valid));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd, input logic [32:0] ex);
    int k;
    @(posedge sys_clk);
    apb_req <= {idx, 2'h0, 1'b1, 1'b0, w, wd};
    if (!w) expq.push_back(ex);
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (k == 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask : apb
  always @(posedge sys_clk) begin
    if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0)
      chk("prdata", {apb_rsp.pslverr, apb_rsp.prdata}, expq.pop_front());
  end
  // Outputs lag one edge, so inputs are frozen at the falling edge before
  task snap;
    @(negedge sys_clk);
    s_si = serial_in;
    s_dsp = dsp_out;
    s_as = asrc_out;
    s_pdm = pdm_in;
    s_rs = rate_strobe;
    @(posedge sys_clk);
    #1;
  endtask : snap
  initial begin
    apb_req = '0;
    rst_b = 1'b0;
    err_total = 0;
    checked = 0;
    seed = 47400;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (n = 0; n < 8; n++) apb(1'b0, 16'hF140 + n, 32'h0, 33'h0);
    for (n = 0; n < 24; n++) apb(1'b0, 16'hF180 + n, 32'h0, 33'h0);
    apb(1'b0, 16'hF148, 32'h0, 33'h100000000);
    apb(1'b0, 16'hF17F, 32'h0, 33'h100000000);
    apb(1'b1, 16'hF100, 32'hFFFFFFFF, 33'h0);
    for (c = 0; c < 8; c++) begin
      for (n = 0; n < 24; n++) begin
        d = $random(seed);
        d[5:0] = {n[2:0], c[2:0]};
        apb(1'b1, 16'hF180 + n, d, 33'h0);
        apb(1'b0, 16'hF180 + n, 32'h0, {27'h0, d[5:0]});
      end
      snap();
      for (n = 0; n < 24; n++) begin
        chk("pair_active", pact[n], c >= 1 && c <= 5);
        for (j = 0; j < 2; j++) begin
          e = c == 1 ? s_si[2*n+j] : c == 2 ? s_dsp[2*n+j] : c == 3 ? s_as[2*(n%8)+j] :
              c == 4 ? s_pdm[j] : c == 5 ? s_pdm[2+j] : 32'h0;
          chk("sout", all_out[2*n+j], e);
        end
      end
    end
    for (c = 0; c < 16; c++) begin
      for (n = 0; n < 8; n++) begin
        d = $random(seed);
        d[3:0] = (c + n) % 16;
        apb(1'b1, 16'hF140 + n, d, 33'h0);
        apb(1'b0, 16'hF140 + n, 32'h0, {29'h0, d[3:0]});
      end
      snap();
      for (n = 0; n < 8; n++) begin
        code = (c + n) % 16;
        v = code >= 1 && code <= 12;
        chk("rate_valid", valid[n], v);
        chk("rate_tick", tick[n], v ? s_rs[code-1] : 1'b0);
      end
    end
    tally_and_finish();
  end
endmodule : test_audio_output_route_and_target_rate_code_select
